// File: peripheral_write_protect_regs.sv
`timescale 1ns/100ps
// How it works
// RULE_01: a zero written to any protection bit leaves that peripheral's state unchanged.
// RULE_02: a one written to clear register 0x00 unprotects; reading shows zero.
// RULE_03: set register 0x04 shares the bit map; a written one protects.
// RULE_04: bridge c bits 15:11 are timers three to seven, 10:8 control timers.
// RULE_05: bridge c bits 7:2 are serial units five down to zero.
// RULE_06: bridge c bit 1 event routing; 16 to 19 adc, comparator, dac, touch.
module peripheral_write_protect_regs
	import protect_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        rst_n,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             protect_event_routing_unit,
	output logic [5:0]       protect_serial_comm_unit,
	output logic [2:0]       protect_control_timer_unit,
	output logic [4:0]       protect_timer_counter_unit,
	output logic             protect_analog_converter,
	output logic             protect_analog_comparator,
	output logic             protect_dac_unit,
	output logic             protect_touch_controller,
	output logic             protect_debug_service_unit,
	output logic             protect_nonvolatile_ctrl,
	output logic             protect_port_unit,
	output logic             protect_dma_unit,
	output logic             protect_trace_buffer
);

	// ************************************************************
	// address decode
	// ************************************************************
	// word compare only: the two low address bits never pick a register
	function automatic logic hit(
		input logic [11:0] addr,
		input logic [11:0] off
	);
		hit = (addr[11:2] == off[11:2]);
	endfunction : hit

	wire logic hit_clear_c = hit(paddr, clear_c_offset);
	wire logic hit_set_c   = hit(paddr, set_c_offset);
	wire logic hit_bank_c  = hit_clear_c | hit_set_c;

	wire logic hit_clear_b = hit(paddr, clear_b_offset);
	wire logic hit_set_b   = hit(paddr, set_b_offset);
	wire logic hit_bank_b  = hit_clear_b | hit_set_b;

	// any other word answers with an error and keeps nothing
	wire logic mapped      = hit_bank_c | hit_bank_b;

	// ************************************************************
	// bus phases
	// ************************************************************
	// pready stays high, so the first access edge always completes
	wire logic setup_phase  = psel & ~penable;
	wire logic access_phase = psel & penable;
	wire logic read_setup   = setup_phase & ~pwrite;
	wire logic write_access = access_phase & pwrite;
	wire logic write_take   = write_access & mapped;

	// ************************************************************
	// byte lanes
	// ************************************************************
	// a lane that pstrb leaves out changes nothing, whatever pwdata holds
	function automatic logic [31:0] lane_mask(
		input logic [3:0] lanes
	);
		lane_mask = {{8{lanes[3]}}, {8{lanes[2]}}, {8{lanes[1]}}, {8{lanes[0]}}};
	endfunction : lane_mask

	wire logic [31:0] byte_mask = lane_mask(pstrb);
	wire logic [31:0] strobed   = pwdata & byte_mask;

	// ************************************************************
	// write commands
	// ************************************************************
	// read-only and absent bits are masked off inside each bank
	wire logic clear_c_take = write_take & hit_clear_c;  // see RULE_02
	wire logic set_c_take   = write_take & hit_set_c;  // see RULE_03
	wire logic clear_b_take = write_take & hit_clear_b;
	wire logic set_b_take   = write_take & hit_set_b;

	bank_write_t wr_c;
	bank_write_t wr_b;

	// one address a cycle, so clear and set never reach a bank together
	assign wr_c = '{
		clear: clear_c_take,
		set:   set_c_take,
		data:  strobed
	};
	assign wr_b = '{
		clear: clear_b_take,
		set:   set_b_take,
		data:  strobed
	};

	// ************************************************************
	// protection banks
	// ************************************************************
	logic [31:0] state_c;
	logic [31:0] state_b;

	// bridge c wakes with bit 23 set; no write can move it
	protect_bank #(
		.reset_value (bridge_c_reset),
		.write_mask  (bridge_c_mask)
	) bank_c (
		.clock (clock),
		.rst_n (rst_n),
		.wr    (wr_c),  // see RULE_02 see RULE_03
		.state (state_c)
	);

	// bridge b wakes with its debug service unit protected
	protect_bank #(
		.reset_value (bridge_b_reset),
		.write_mask  (bridge_b_mask)
	) bank_b (
		.clock (clock),
		.rst_n (rst_n),
		.wr    (wr_b),
		.state (state_b)
	);

	// ************************************************************
	// read path, answered in the access phase with no wait state
	// ************************************************************
	// both addresses of a bank read back the same protection state
	wire logic [31:0] read_c      = hit_bank_c ? state_c : 32'h00000000;
	wire logic [31:0] read_b      = hit_bank_b ? state_b : 32'h00000000;
	wire logic [31:0] read_value  = read_c | read_b;
	wire logic [31:0] next_prdata = read_setup ? read_value : 32'h00000000;

	// loaded in the setup phase, held through the access phase
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			prdata <= 32'h00000000;
		end else if (setup_phase) begin
			prdata <= next_prdata;  // see RULE_02
		end
	end

	// ************************************************************
	// error response
	// ************************************************************
	// flagged in the setup phase so it stands with the access phase
	wire logic next_pslverr = ~mapped;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			pslverr <= 1'b0;
		end else if (setup_phase) begin
			pslverr <= next_pslverr;
		end
	end

	// no wait state: every transfer ends at its first access edge
	assign pready = 1'b1;

	// ************************************************************
	// bridge c fields
	// ************************************************************
	// lowest bit of each group is the lowest numbered unit
	wire logic       field_event_routing     = state_c[event_routing_unit_bit];  // see RULE_06
	wire logic [5:0] field_serial_comm       =
		state_c[serial_comm_unit_msb:serial_comm_unit_lsb];  // see RULE_05
	wire logic [2:0] field_control_timer     =
		state_c[control_timer_unit_msb:control_timer_unit_lsb];  // see RULE_04
	wire logic [4:0] field_timer_counter     =
		state_c[timer_counter_unit_msb:timer_counter_unit_lsb];  // see RULE_04

	wire logic       field_analog_converter  = state_c[analog_converter_bit];  // see RULE_06
	wire logic       field_analog_comparator = state_c[analog_comparator_bit];  // see RULE_06
	wire logic       field_dac               = state_c[dac_unit_bit];  // see RULE_06
	wire logic       field_touch_controller  = state_c[touch_controller_bit];  // see RULE_06

	// ************************************************************
	// bridge b fields
	// ************************************************************
	// bit 5 of bridge b holds nothing and reads as zero
	wire logic field_debug_service = state_b[debug_service_unit_bit];
	wire logic field_nonvolatile   = state_b[nonvolatile_ctrl_bit];
	wire logic field_port          = state_b[port_unit_bit];
	wire logic field_dma           = state_b[dma_unit_bit];
	wire logic field_trace_buffer  = state_b[trace_buffer_bit];

	// ************************************************************
	// bridge c levels
	// ************************************************************
	// levels come straight from the bank flops
	assign protect_event_routing_unit = field_event_routing;
	assign protect_serial_comm_unit   = field_serial_comm;
	assign protect_control_timer_unit = field_control_timer;
	assign protect_timer_counter_unit = field_timer_counter;
	assign protect_analog_converter   = field_analog_converter;
	assign protect_analog_comparator  = field_analog_comparator;
	assign protect_dac_unit           = field_dac;
	assign protect_touch_controller   = field_touch_controller;

	// ************************************************************
	// bridge b levels
	// ************************************************************
	assign protect_debug_service_unit = field_debug_service;
	assign protect_nonvolatile_ctrl   = field_nonvolatile;
	assign protect_port_unit          = field_port;
	assign protect_dma_unit           = field_dma;
	assign protect_trace_buffer       = field_trace_buffer;

endmodule : peripheral_write_protect_regs

// File: protect_bank.sv
`timescale 1ns/100ps
module protect_bank
	import protect_pkg::*;
#(
	parameter logic [31:0] reset_value = 32'h00000000,
	parameter logic [31:0] write_mask  = 32'h00000000
) (
	input  wire logic        clock,
	input  wire logic        rst_n,
	input  wire bank_write_t wr,
	output logic [31:0]      state
);

	wire logic [31:0] ones = wr.data & write_mask;
	wire logic [31:0] next_state = wr.clear ? (state & ~ones) :
	                               wr.set   ? (state | ones)  : state;

	// zero bits leave the state alone; clear removes, set adds protection
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state <= reset_value;
		end else begin
			state <= next_state;  // see RULE_01 see RULE_02 see RULE_03
		end
	end

endmodule : protect_bank

// File: protect_monitor.sv
`timescale 1ns/100ps
module protect_monitor (
	input wire logic        clock,
	input wire logic        rst_n,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0]  pstrb,
	input wire logic        protect_event_routing_unit,
	input wire logic        protect_analog_converter,
	input wire logic        protect_analog_comparator,
	input wire logic        protect_dac_unit,
	input wire logic        protect_touch_controller,
	input wire logic [5:0]  protect_serial_comm_unit,
	input wire logic [2:0]  protect_control_timer_unit,
	input wire logic [4:0]  protect_timer_counter_unit
);
	wire logic        wr_c  = psel && penable && pwrite && paddr[11:3] == 9'h000;
	wire logic        set_c = wr_c && paddr[2];
	wire logic [3:0]  ana   = {protect_touch_controller, protect_dac_unit,
		protect_analog_comparator, protect_analog_converter};
	wire logic [19:0] st_c  = {ana, protect_timer_counter_unit, protect_control_timer_unit,
		protect_serial_comm_unit, protect_event_routing_unit, 1'b0};
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	a_zero_no_change: assert property (wr_c && pwdata == 32'h0 |=> $stable(st_c))
		else $error("zero write changed state");
	a_clear_event: assert property (wr_c && !paddr[2] && pwdata[1] && pstrb[0]
		|=> !protect_event_routing_unit) else $error("clear did not unprotect");
	a_set_event: assert property (set_c && pwdata[1] && pstrb[0]
		|=> protect_event_routing_unit) else $error("set did not protect");
	a_timer_fields: assert property (set_c && pstrb[1] && pwdata[15:8] == 8'hFF
		|=> protect_timer_counter_unit == 5'h1F && protect_control_timer_unit == 3'h7)
		else $error("timer field map wrong");
	a_serial_zero: assert property (set_c && pstrb[0] && pwdata[2]
		|=> protect_serial_comm_unit[0]) else $error("serial unit zero map wrong");
	a_analog_order: assert property (set_c && pstrb[2]
		|=> (ana & $past(pwdata[19:16])) == $past(pwdata[19:16])) else $error("analog map wrong");
endmodule : protect_monitor

bind peripheral_write_protect_regs protect_monitor mon (.*);

// File: protect_pkg.sv
package protect_pkg;

	// ************************************************************
	// register map
	// ************************************************************
	localparam logic [11:0] clear_c_offset = 12'h000;
	localparam logic [11:0] set_c_offset   = 12'h004;
	localparam logic [11:0] clear_b_offset = 12'h010;
	localparam logic [11:0] set_b_offset   = 12'h014;

	// ************************************************************
	// reset values and writable bits
	// ************************************************************
	localparam logic [31:0] bridge_b_reset = 32'h00000002;
	localparam logic [31:0] bridge_c_reset = 32'h00800000;
	localparam logic [31:0] bridge_b_mask  = 32'h0000005E;
	localparam logic [31:0] bridge_c_mask  = 32'h000FFFFE;

	// ************************************************************
	// field positions, bridge c
	// ************************************************************
	localparam int event_routing_unit_bit  = 1;
	localparam int serial_comm_unit_lsb    = 2;
	localparam int serial_comm_unit_msb    = 7;
	localparam int control_timer_unit_lsb  = 8;
	localparam int control_timer_unit_msb  = 10;
	localparam int timer_counter_unit_lsb  = 11;
	localparam int timer_counter_unit_msb  = 15;
	localparam int analog_converter_bit    = 16;
	localparam int analog_comparator_bit   = 17;
	localparam int dac_unit_bit            = 18;
	localparam int touch_controller_bit    = 19;

	// ************************************************************
	// field positions, bridge b
	// ************************************************************
	localparam int debug_service_unit_bit  = 1;
	localparam int nonvolatile_ctrl_bit    = 2;
	localparam int port_unit_bit           = 3;
	localparam int dma_unit_bit            = 4;
	localparam int trace_buffer_bit        = 6;

	typedef struct packed {
		logic        clear;
		logic        set;
		logic [31:0] data;
	} bank_write_t;

endpackage : protect_pkg

// File: tb.sv
`timescale 1ns/100ps
module tb
	import protect_pkg::*;
;
	logic clock = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, err;
	logic [11:0] paddr = 0;
	logic [3:0]  pstrb = 0;
	logic [31:0] pwdata = 0, rd, exp_c, exp_b;
	logic [11:0] ad [8] = '{12'h000, 12'h004, 12'h010, 12'h014, 12'h001, 12'h006, 12'h008, 12'h018};
	int          errors = 0, cmp_count = 0, cycles = 0, seed = 39801;
	wire logic [31:0] prdata;
	wire logic [5:0]  protect_serial_comm_unit;
	wire logic [2:0]  protect_control_timer_unit;
	wire logic [4:0]  protect_timer_counter_unit;
	wire logic pready, pslverr, protect_event_routing_unit, protect_analog_converter,
		protect_analog_comparator, protect_dac_unit, protect_touch_controller, protect_port_unit,
		protect_debug_service_unit, protect_nonvolatile_ctrl, protect_dma_unit, protect_trace_buffer;
	wire logic [19:0] st_c = {protect_touch_controller, protect_dac_unit, protect_analog_comparator,
		protect_analog_converter, protect_timer_counter_unit, protect_control_timer_unit,
		protect_serial_comm_unit, protect_event_routing_unit, 1'b0};
	wire logic [6:0]  st_b = {protect_trace_buffer, 1'b0, protect_dma_unit, protect_port_unit,
		protect_nonvolatile_ctrl, protect_debug_service_unit, 1'b0};
	peripheral_write_protect_regs uut (.*);
	always #12.5 clock = ~clock;
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			errors = errors + 1;
			complete_run();
		end
	end
	function automatic logic [31:0] upd(logic [31:0] st, logic [31:0] dd, logic [3:0] s,
		logic set, logic [31:0] m);
		logic [31:0] k;
		k = dd & m & {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
		return set ? (st | k) : (st & ~k);
	endfunction : upd
	task chk(input logic [31:0] got, input logic [31:0] want);
		cmp_count++;
		if (got !== want) begin
			errors++;
			$display("CHECK FAILED %0t got %h want %h", $time, got, want);
		end
	endtask : chk
	task apb(input logic w, input logic [11:0] a, input logic [31:0] dd, input logic [3:0] s);
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= dd;
		pstrb <= s;
		@(posedge clock);
		penable <= 1'b1;
		do @(posedge clock); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task wr_chk(input logic [11:0] a, input logic [31:0] dd, input logic [3:0] s);
		apb(1'b1, a, dd, s);
		if (a[11:3] == 9'h000) exp_c = upd(exp_c, dd, s, a[2], bridge_c_mask);
		if (a[11:3] == 9'h002) exp_b = upd(exp_b, dd, s, a[2], bridge_b_mask);
		apb(1'b0, a, 32'h0, 4'h0);
		chk(rd, a[11:3] == 9'h000 ? exp_c : a[11:3] == 9'h002 ? exp_b : 32'h0);
		chk({31'h0, err}, {31'h0, a[11:3] != 9'h000 && a[11:3] != 9'h002});
		chk({12'h000, st_c}, {12'h000, exp_c[19:0]});
		chk({25'h0, st_b}, {25'h0, exp_b[6:0]});
	endtask : wr_chk
	task complete_run();
		$display("comparisons %0d mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : complete_run
	initial begin
		exp_c = bridge_c_reset;
		exp_b = bridge_b_reset;
		repeat (6) @(posedge clock);
		rst_n <= 1'b1;
		wr_chk(12'h000, 32'hFFFFFFFF, 4'h0);
		wr_chk(12'h010, 32'hFFFFFFFF, 4'h0);
		wr_chk(12'h008, 32'hFFFFFFFF, 4'hF);
		wr_chk(12'h004, 32'hFFFFFFFF, 4'hF);
		wr_chk(12'h000, 32'h00000000, 4'hF);
		wr_chk(12'h000, 32'h0000F00A, 4'hE);
		wr_chk(12'h004, 32'h00050024, 4'hF);
		wr_chk(12'h014, 32'hFFFFFFFF, 4'hF);
		wr_chk(12'h010, 32'h0000005E, 4'h1);
		$display("test corners done");
		for (int i = 0; i < 80; i++)
			wr_chk(ad[$random(seed) & 7], $random(seed), 4'($random(seed)));
		$display("test random done");
		rst_n <= 1'b0;
		@(posedge clock);
		rst_n <= 1'b1;
		exp_c = bridge_c_reset;
		exp_b = bridge_b_reset;
		wr_chk(12'h004, 32'h00000000, 4'hF);
		wr_chk(12'h014, 32'h00000000, 4'hF);
		$display("test reset done");
		complete_run();
	end
endmodule : tb
